// File: cto_tx_output_control.v
`timescale 1ns/10ps
`include "cto_map.vh"
module cto_tx_output_control (
  // clock and reset
  input  wire        ref_clk,
  input  wire        arst_n,
  // i2c register port
  input  wire        scl,
  input  wire        sdaIn,
  output reg         sdaOut,
  output reg         sdaOe,
  // device pins and receiver lock
  input  wire        powerDownPinN,
  input  wire [1:0]  rxLock,
  // receive video streams
  input  wire [15:0] rxData,
  input  wire [1:0]  rxValid,
  input  wire [1:0]  rxLast,
  input  wire [1:0]  rxError,
  output wire [1:0]  rxReady,
  // transmit streams
  output wire [15:0] txData,
  output wire [1:0]  txValid,
  output wire [1:0]  txLast,
  input  wire [1:0]  txReady,
  // transmitter pin and timing control
  output reg  [3:0]  txPinState,
  output reg  [1:0]  txClkLaneEn,
  output reg  [1:0]  txLaneCount,
  output reg  [63:0] txTiming0,
  output reg  [63:0] txTiming1,
  // rate and status
  output reg  [1:0]  txRateSel,
  output reg         pllLowRate,
  output reg         refScaleAlt,
  output reg         txStatusOut,
  output reg         statusChange
);
  localparam [2:0] I2C_IDLE  = 3'd0;
  localparam [2:0] I2C_RX    = 3'd1;
  localparam [2:0] I2C_RXACK = 3'd2;
  localparam [2:0] I2C_TX    = 3'd3;
  localparam [2:0] I2C_TXACK = 3'd4;
  localparam [63:0] TIM_RESET = `CTO_TIM_RESET;

  reg  [4:0]  syncA;
  reg  [4:0]  syncB;
  reg         sclD;
  reg         sdaD;
  reg  [2:0]  i2cState;
  reg  [3:0]  bitCnt;
  reg  [7:0]  shiftReg;
  reg         gotAddr;
  reg         hasPtr;
  reg         isRead;
  reg         nack;
  reg  [7:0]  regPtr;
  reg         wrStb;
  reg  [7:0]  wrAddr;
  reg  [7:0]  wrData;
  reg  [7:0]  genCfg;
  reg  [7:0]  rateSel;
  reg  [7:0]  fwdCtl1;
  reg  [7:0]  fwdCtl2;
  reg  [7:0]  txCtl;
  reg  [7:0]  indCtl;
  reg  [7:0]  indIdx;
  reg  [7:0]  timProg [0:15];
  reg  [7:0]  statusReg;
  reg  [1:0]  engBusy;
  reg  [1:0]  engSrc;
  reg  [1:0]  errSeen;
  reg  [1:0]  bufTake;
  reg  [1:0]  skInVal;
  reg  [17:0] skInDat;
  reg  [7:0]  next_status;
  reg  [3:0]  next_pin;
  reg  [1:0]  mask;
  reg         lockAny;
  reg         allDis;
  integer     i;
  integer     t;
  integer     e;
  integer     s;

  wire [1:0]  bufValid;
  wire [1:0]  bufLast;
  wire [15:0] bufData;
  wire [1:0]  skRdy;
  wire        sclS = syncB[0];
  wire        sdaS = syncB[1];
  wire        pdbS = syncB[2];
  wire [1:0]  lockS = syncB[4:3];
  wire        sclRise = sclS & ~sclD;
  wire        sclFall = ~sclS & sclD;
  wire        startCond = sclS & sclD & sdaD & ~sdaS;
  wire        stopCond = sclS & sclD & ~sdaD & sdaS;
  wire        txEn = txCtl[`CTO_TXC_ENABLE];
  wire        replicate = fwdCtl2[`CTO_FWD2_REPLICATE];
  wire [1:0]  rxMap = fwdCtl1[1:0];
  wire [1:0]  rxDis = fwdCtl1[`CTO_FWD1_DIS_LO+1:`CTO_FWD1_DIS_LO];
  wire        timHit = (indCtl[`CTO_IND_PAGE_LO+2:`CTO_IND_PAGE_LO] == 3'h0) &&
                       (indIdx[7:6] == 2'b01) && (indIdx[4:3] == 2'b00);
  wire [3:0]  timSel = {indIdx[`CTO_IND_PORT_BIT], indIdx[2:0]};
  wire [7:0]  rdByte = regRead(regPtr);
  wire        autoRate = (rateSel[1:0] == `CTO_RATE_1G6) || (rateSel[1:0] == `CTO_RATE_800);
  wire        useProg = !autoRate && txCtl[`CTO_TXC_OVERRIDE];
  wire [63:0] prog0 = {timProg[7], timProg[6], timProg[5], timProg[4],
                       timProg[3], timProg[2], timProg[1], timProg[0]};
  wire [63:0] prog1 = {timProg[15], timProg[14], timProg[13], timProg[12],
                       timProg[11], timProg[10], timProg[9], timProg[8]};
  wire [8:0]  eng0 = engSrc[0] ? {bufLast[1], bufData[15:8]} : {bufLast[0], bufData[7:0]};
  wire [8:0]  eng1 = engSrc[1] ? {bufLast[1], bufData[15:8]} : {bufLast[0], bufData[7:0]};
  wire        engVal0 = engBusy[0] & bufValid[engSrc[0]];
  wire        engVal1 = engBusy[1] & bufValid[engSrc[1]];
  wire [1:0]  sinkRdy = {skRdy[1] & ~replicate, skRdy[0] & (~replicate | skRdy[1])};
  // sources each engine may claim; engine 1 sits idle while replicating
  wire [3:0]  engMask = {rxMap & bufValid & ~rxDis & {2{txEn & ~replicate}}, ~rxMap & bufValid & ~rxDis & {2{txEn}}};

  // register readback decode
  function [7:0] regRead;
    input [7:0] a;
    begin
      if (a == `CTO_REG_GEN_CFG) regRead = genCfg;
      else if (a == `CTO_REG_RATE) regRead = rateSel;
      else if (a == `CTO_REG_FWD1) regRead = fwdCtl1;
      else if (a == `CTO_REG_FWD2) regRead = fwdCtl2;
      else if (a == `CTO_REG_TX_CTL) regRead = txCtl;
      else if (a == `CTO_REG_TX_STS) regRead = statusReg;
      else if (a == `CTO_REG_IND_CTL) regRead = indCtl;
      else if (a == `CTO_REG_IND_IDX) regRead = indIdx;
      else if (a == `CTO_REG_IND_DATA) regRead = timHit ? timProg[timSel] : 8'h00;
      else regRead = 8'h00;
    end
  endfunction

  // two-stage synchronisers for pins, then edge history
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA <= 5'h03;
      syncB <= 5'h03;
      sclD  <= 1'b1;
      sdaD  <= 1'b1;
    end else begin
      syncA <= {rxLock, powerDownPinN, sdaIn, scl};
      syncB <= syncA;
      sclD  <= sclS;
      sdaD  <= sdaS;
    end
  end

  // i2c slave: address, pointer, then data bytes with pointer increment
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      i2cState <= I2C_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      gotAddr  <= 1'b0;
      hasPtr   <= 1'b0;
      isRead   <= 1'b0;
      nack     <= 1'b0;
      regPtr   <= 8'h00;
      wrStb    <= 1'b0;
      wrAddr   <= 8'h00;
      wrData   <= 8'h00;
      sdaOut   <= 1'b0;
      sdaOe    <= 1'b0;
    end else begin
      wrStb <= 1'b0;
      if (startCond) begin
        i2cState <= I2C_RX;
        bitCnt   <= 4'h0;
        gotAddr  <= 1'b0;
        hasPtr   <= 1'b0;
        sdaOe    <= 1'b0;
      end else if (stopCond) begin
        i2cState <= I2C_IDLE;
        sdaOe    <= 1'b0;
      end else if (sclRise) begin
        if (i2cState == I2C_RX && bitCnt != 4'h8) begin
          shiftReg <= {shiftReg[6:0], sdaS};
          bitCnt   <= bitCnt + 4'h1;
        end
        if (i2cState == I2C_TXACK) nack <= sdaS;
      end else if (sclFall) begin
        case (i2cState)
          I2C_RX: begin
            if (bitCnt == 4'h8) begin
              bitCnt   <= 4'h0;
              i2cState <= I2C_RXACK;
              sdaOe    <= 1'b1;
              if (!gotAddr) begin
                if (shiftReg[7:1] == `CTO_I2C_ADDR) begin
                  gotAddr <= 1'b1;
                  isRead  <= shiftReg[0];
                end else begin
                  i2cState <= I2C_IDLE;
                  sdaOe    <= 1'b0;
                end
              end else if (!hasPtr) begin
                hasPtr <= 1'b1;
                regPtr <= shiftReg;
              end else begin
                wrStb  <= 1'b1;
                wrAddr <= regPtr;
                wrData <= shiftReg;
                regPtr <= regPtr + 8'h01;
              end
            end
          end
          I2C_RXACK: begin
            if (isRead) begin
              shiftReg <= rdByte;
              sdaOe    <= ~rdByte[7];
              regPtr   <= regPtr + 8'h01;
              i2cState <= I2C_TX;
            end else begin
              sdaOe    <= 1'b0;
              i2cState <= I2C_RX;
            end
          end
          I2C_TX: begin
            if (bitCnt == 4'h7) begin
              sdaOe    <= 1'b0;
              i2cState <= I2C_TXACK;
            end else begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOe    <= ~shiftReg[6];
              bitCnt   <= bitCnt + 4'h1;
            end
          end
          I2C_TXACK: begin
            bitCnt <= 4'h0;
            if (nack) begin
              i2cState <= I2C_IDLE;
            end else begin
              shiftReg <= rdByte;
              sdaOe    <= ~rdByte[7];
              regPtr   <= regPtr + 8'h01;
              i2cState <= I2C_TX;
            end
          end
          default: i2cState <= I2C_IDLE;
        endcase
      end
    end
  end

  // register writes; status register has no write path
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      genCfg  <= `CTO_RST_GEN_CFG;
      rateSel <= `CTO_RST_RATE;
      fwdCtl1 <= `CTO_RST_FWD1;
      fwdCtl2 <= `CTO_RST_FWD2;
      txCtl   <= `CTO_RST_TX_CTL;
      indCtl  <= `CTO_RST_IND;
      indIdx  <= `CTO_RST_IND;
      for (i = 0; i < 16; i = i + 1) begin
        timProg[i] <= TIM_RESET[8*(i%8) +: 8];
      end
    end else if (wrStb) begin
      if (wrAddr == `CTO_REG_GEN_CFG) genCfg <= wrData;
      else if (wrAddr == `CTO_REG_RATE) rateSel <= wrData;
      else if (wrAddr == `CTO_REG_FWD1) fwdCtl1 <= wrData;
      else if (wrAddr == `CTO_REG_FWD2) fwdCtl2 <= wrData;
      else if (wrAddr == `CTO_REG_TX_CTL) txCtl <= wrData;
      else if (wrAddr == `CTO_REG_IND_CTL) indCtl <= wrData;
      else if (wrAddr == `CTO_REG_IND_IDX) indIdx <= wrData;
      else if (wrAddr == `CTO_REG_IND_DATA) begin
        if (timHit) timProg[timSel] <= wrData;
        if (indCtl[`CTO_IND_AUTOINC]) indIdx <= indIdx + 8'h01;
      end
    end
  end

  // per-port line buffers
  genvar r;
  generate
    for (r = 0; r < 2; r = r + 1) begin : gBuf
      cto_line_buffer uBuf (
        .clk      (ref_clk),
        .arst_n   (arst_n),
        .inValid  (rxValid[r]),
        .inData   ({rxLast[r], rxData[8*r +: 8]}),
        .inReady  (rxReady[r]),
        .outValid (bufValid[r]),
        .outData  ({bufLast[r], bufData[8*r +: 8]}),
        .outReady (bufTake[r])
      );
      cto_skid_buffer #(.WIDTH(9)) uSkid (
        .clk      (ref_clk),
        .arst_n   (arst_n),
        .inValid  (skInVal[r]),
        .inData   (skInDat[9*r +: 9]),
        .inReady  (skRdy[r]),
        .outValid (txValid[r]),
        .outData  ({txLast[r], txData[8*r +: 8]}),
        .outReady (txReady[r])
      );
    end
  endgenerate

  // drain steering; replicate feeds both outputs from engine 0
  always @* begin
    bufTake = 2'b00;
    if (engBusy[0] && sinkRdy[0]) bufTake[engSrc[0]] = 1'b1;
    if (engBusy[1] && sinkRdy[1]) bufTake[engSrc[1]] = 1'b1;
    skInVal[0] = engVal0 & (~replicate | skRdy[1]);
    skInVal[1] = replicate ? (engVal0 & skRdy[0]) : engVal1;
    skInDat[8:0]  = eng0;
    skInDat[17:9] = replicate ? eng0 : eng1;
  end

  // engines lock onto a source for a whole packet, alternating on contention
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      engBusy <= 2'b00;
      engSrc  <= 2'b00;
      errSeen <= 2'b00;
    end else begin
      for (e = 0; e < 2; e = e + 1) begin
        if (!engBusy[e]) begin
          errSeen[e] <= 1'b0;
          if (engMask[2*e +: 2] != 2'b00) begin
            engBusy[e] <= 1'b1;
            engSrc[e]  <= (engMask[2*e +: 2] == 2'b11) ? ~engSrc[e] : engMask[2*e+1];
          end
        end else begin
          if (rxError[engSrc[e]]) errSeen[e] <= 1'b1;
          if (bufTake[engSrc[e]] && bufValid[engSrc[e]] && bufLast[engSrc[e]]) engBusy[e] <= 1'b0;
        end
      end
    end
  end

  // pin state and status per output port
  always @* begin
    next_status = 8'h00;
    next_pin    = 4'h0;
    for (t = 0; t < 2; t = t + 1) begin
      mask    = (t == 1 && !replicate) ? rxMap : ~rxMap;
      lockAny = |(lockS & mask);
      allDis  = &(rxDis | ~mask);
      if (!pdbS) next_pin[2*t +: 2] = `CTO_PIN_HIZ;
      else if (!genCfg[`CTO_GEN_SLEEP_SEL]) next_pin[2*t +: 2] = `CTO_PIN_HS0;
      else if (!genCfg[`CTO_GEN_OEN]) next_pin[2*t +: 2] = `CTO_PIN_HIZ;
      else if (!txEn) next_pin[2*t +: 2] = `CTO_PIN_HIZ;
      else if (!lockAny) begin
        if (genCfg[`CTO_GEN_INACT_MODE]) next_pin[2*t +: 2] = `CTO_PIN_LP11;
        else next_pin[2*t +: 2] = `CTO_PIN_HIZ;
      end else if (allDis || !txValid[t]) next_pin[2*t +: 2] = `CTO_PIN_LP11;
      else next_pin[2*t +: 2] = `CTO_PIN_HS;
      s = (replicate && t == 1) ? 0 : t;
      next_status[4*t] = txEn & engBusy[s] & ~errSeen[s] & ~rxError[engSrc[s]];
      next_status[4*t+1] = fwdCtl2[`CTO_FWD2_SYNC_EN] & (&mask) & (&lockS) & ~(|rxDis);
    end
  end

  // registered outputs: pins, status, timing and rate controls
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      txPinState   <= 4'h0;
      statusReg    <= 8'h00;
      statusChange <= 1'b0;
      txStatusOut  <= 1'b0;
      txClkLaneEn  <= 2'b00;
      txLaneCount  <= 2'b00;
      txTiming0    <= 64'h0000000000000000;
      txTiming1    <= 64'h0000000000000000;
      txRateSel    <= 2'b00;
      pllLowRate   <= 1'b0;
      refScaleAlt  <= 1'b0;
    end else begin
      txPinState   <= next_pin;
      statusReg    <= next_status;
      statusChange <= (next_status != statusReg);
      txStatusOut  <= next_status[0];
      txClkLaneEn  <= {txEn & (replicate | (|rxMap)), txEn};
      txLaneCount  <= txCtl[`CTO_TXC_LANE_LO+1:`CTO_TXC_LANE_LO];
      txTiming0    <= useProg ? prog0 : `CTO_TIM_AUTO;
      txTiming1    <= useProg ? (replicate ? prog0 : prog1) : `CTO_TIM_AUTO;
      txRateSel    <= rateSel[1:0];
      pllLowRate   <= (rateSel[1:0] == `CTO_RATE_400);
      refScaleAlt  <= (rateSel[1:0] == `CTO_RATE_ALT);
    end
  end
endmodule // cto_tx_output_control

// File: cto_map.vh
`ifndef CTO_MAP_VH
`define CTO_MAP_VH

// i2c device address
`define CTO_I2C_ADDR        7'h3D
// register offsets
`define CTO_REG_GEN_CFG     8'h02
`define CTO_REG_RATE        8'h1F
`define CTO_REG_FWD1        8'h20
`define CTO_REG_FWD2        8'h21
`define CTO_REG_TX_CTL      8'h33
`define CTO_REG_TX_STS      8'h35
`define CTO_REG_IND_CTL     8'hB0
`define CTO_REG_IND_IDX     8'hB1
`define CTO_REG_IND_DATA    8'hB2
// field positions
`define CTO_GEN_OEN         0
`define CTO_GEN_SLEEP_SEL   1
`define CTO_GEN_INACT_MODE  2
`define CTO_FWD1_DIS_LO     4
`define CTO_FWD2_SYNC_EN    0
`define CTO_FWD2_REPLICATE  5
`define CTO_TXC_ENABLE      0
`define CTO_TXC_LANE_LO     4
`define CTO_TXC_OVERRIDE    6
`define CTO_IND_AUTOINC     1
`define CTO_IND_PAGE_LO     2
`define CTO_IND_PORT_BIT    5
// reset values and the automatic-rate timing table
`define CTO_RST_GEN_CFG     8'h03
`define CTO_RST_RATE        8'h00
`define CTO_RST_FWD1        8'h30
`define CTO_RST_FWD2        8'h00
`define CTO_RST_TX_CTL      8'h10
`define CTO_RST_IND         8'h00
`define CTO_TIM_RESET       64'h8684868387878D83
`define CTO_TIM_AUTO        64'h0A060A060A0A140A
// lane rate codes
`define CTO_RATE_1G6        2'b00
`define CTO_RATE_ALT        2'b01
`define CTO_RATE_800        2'b10
`define CTO_RATE_400        2'b11
// output pin states
`define CTO_PIN_HIZ         2'b00
`define CTO_PIN_LP11        2'b01
`define CTO_PIN_HS0         2'b10
`define CTO_PIN_HS          2'b11
// line buffer geometry
`define CTO_BUF_DEPTH       16384
`define CTO_BUF_AW          14
`endif

// File: cto_line_buffer.v
`timescale 1ns/10ps
`include "cto_map.vh"
module cto_line_buffer #(
  parameter DEPTH = `CTO_BUF_DEPTH,
  parameter AW    = `CTO_BUF_AW
) (
  // clock and reset
  input  wire       clk,
  input  wire       arst_n,
  // fill side, bit 8 marks the last byte of a packet
  input  wire       inValid,
  input  wire [8:0] inData,
  output reg        inReady,
  // drain side
  output wire       outValid,
  output wire [8:0] outData,
  input  wire       outReady
);
  localparam [AW:0] FULL = DEPTH;
  reg  [8:0]  mem [0:DEPTH-1];
  reg  [AW-1:0] wrPtr;
  reg  [AW-1:0] rdPtr;
  reg  [AW:0] count;
  reg  [AW:0] pktCount;
  wire        push = inValid & inReady;
  wire        pop  = outValid & outReady;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // drain offered only once a whole packet sits in storage
  assign outValid = (pktCount != {(AW+1){1'b0}});
  assign outData  = mem[rdPtr];

  // payload storage, one per receive port
  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers, fill level and complete-packet count
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr    <= {AW{1'b0}};
      rdPtr    <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      pktCount <= {(AW+1){1'b0}};
      inReady  <= 1'b0;
    end else begin
      if (push) wrPtr <= wrPtr + {{(AW-1){1'b0}}, 1'b1};
      if (pop) rdPtr <= rdPtr + {{(AW-1){1'b0}}, 1'b1};
      count    <= next_count;
      pktCount <= pktCount + {{AW{1'b0}}, push & inData[8]} - {{AW{1'b0}}, pop & outData[8]};
      inReady  <= (next_count != FULL);
    end
  end
endmodule // cto_line_buffer

// File: cto_skid_buffer.v
`timescale 1ns/10ps
module cto_skid_buffer #(
  parameter WIDTH = 9
) (
  // clock and reset
  input  wire             clk,
  input  wire             arst_n,
  // fill side
  input  wire             inValid,
  input  wire [WIDTH-1:0] inData,
  output reg              inReady,
  // drain side
  output reg              outValid,
  output reg  [WIDTH-1:0] outData,
  input  wire             outReady
);
  reg  [WIDTH-1:0] spare;
  reg  [1:0]       cnt;
  wire             push = inValid & inReady;
  wire             pop  = outValid & outReady;
  wire [1:0]       next_cnt = cnt + {1'b0, push} - {1'b0, pop};

  // two entries so a stalled receiver loses no word
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spare    <= {WIDTH{1'b0}};
      outData  <= {WIDTH{1'b0}};
      cnt      <= 2'h0;
      outValid <= 1'b0;
      inReady  <= 1'b0;
    end else begin
      if (pop && !push) begin
        outData <= spare;
      end else if (push && !pop) begin
        if (cnt == 2'h0) outData <= inData;
        else spare <= inData;
      end else if (push && pop) begin
        if (cnt == 2'h1) begin
          outData <= inData;
        end else begin
          outData <= spare;
          spare   <= inData;
        end
      end
      cnt      <= next_cnt;
      outValid <= (next_cnt != 2'h0);
      inReady  <= (next_cnt != 2'h2);
    end
  end
endmodule // cto_skid_buffer

// File: cto_csi_sink.sv
`timescale 1ns/10ps
module cto_csi_sink #(
  parameter SEED = 52
) (
  // clock
  input  wire        clk,
  // streams from the hub, ready back
  input  wire [15:0] txData,
  input  wire [1:0]  txValid,
  input  wire [1:0]  txLast,
  output reg  [1:0]  txReady
);
  integer     seed = SEED;
  integer     rnd;
  logic [8:0] q0[$];
  logic [8:0] q1[$];
  // ready is low until the first edge so no word is taken blind
  initial txReady = 2'h0;
  // keep accepted bytes with their last marks, stall at random
  always @(posedge clk) begin
    rnd = $random(seed);
    if (txValid[0] && txReady[0]) q0.push_back({txLast[0], txData[7:0]});
    if (txValid[1] && txReady[1]) q1.push_back({txLast[1], txData[15:8]});
    txReady <= rnd[1:0];
  end
endmodule // cto_csi_sink

// File: cto_tx_output_control_checker.sv
`timescale 1ns/10ps
`include "cto_map.vh"
module cto_tx_output_control_checker (
  // clock and reset
  input logic        ref_clk,
  input logic        arst_n,
  // pins and streams
  input logic        powerDownPinN,
  input logic        sdaOut,
  input logic [1:0]  txValid,
  input logic [1:0]  txReady,
  input logic [15:0] txData,
  input logic [1:0]  txLast,
  input logic [3:0]  txPinState,
  // rate and status
  input logic [63:0] txTiming0,
  input logic [1:0]  txRateSel,
  input logic        pllLowRate,
  input logic        refScaleAlt,
  input logic        txStatusOut,
  input logic        statusChange
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // a word held back by the receiver on each port
  sequence stall0; txValid[0] && !txReady[0]; endsequence
  sequence stall1; txValid[1] && !txReady[1]; endsequence
  // rate flags, timing table, stream hold, status event, power-down, open drain
  a_low_rate: assert property ($stable(txRateSel) [*2] |-> pllLowRate == (txRateSel == 2'h3))
    else $error("low rate flag wrong");
  a_alt_scale: assert property ($stable(txRateSel) [*2] |-> refScaleAlt == (txRateSel == 2'h1))
    else $error("alt scale flag wrong");
  a_auto_timing: assert property ((txRateSel[0] == 1'b0) [*4] |-> txTiming0 == `CTO_TIM_AUTO)
    else $error("auto timing not used");
  a_hold_low: assert property (stall0 |=> txValid[0] && $stable(txData[7:0]) && $stable(txLast[0]))
    else $error("port 0 word lost");
  a_hold_high: assert property (stall1 |=> txValid[1] && $stable(txData[15:8]) && $stable(txLast[1]))
    else $error("port 1 word lost");
  a_status_event: assert property ($changed(txStatusOut) |-> ($past(statusChange) || statusChange) or ##[1:3] statusChange)
    else $error("status change not flagged");
  a_pdn_hiz: assert property ((!powerDownPinN) [*5] |-> txPinState == 4'h0)
    else $error("pins driven in power-down");
  a_sda_low: assert property (sdaOut == 1'b0)
    else $error("sda driven high");
endmodule // cto_tx_output_control_checker
bind cto_tx_output_control cto_tx_output_control_checker u_chk (.*);

// File: cto_tx_output_control_tb.sv
`timescale 1ns/10ps
`include "cto_map.vh"
module cto_tx_output_control_tb;
  // design inputs
  reg        ref_clk = 1'b0, arst_n = 1'b0, scl = 1'b1, sdaM = 1'b1, powerDownPinN = 1'b1;
  reg [1:0]  rxLock = 2'h0, rxValid = 2'h0, rxLast = 2'h0, rxError = 2'h0;
  reg [15:0] rxData = 16'h0000;
  // design outputs and the open-drain data line
  wire        sdaOut, sdaOe, pllLowRate, refScaleAlt, txStatusOut, statusChange;
  wire [1:0]  rxReady, txValid, txLast, txReady, txClkLaneEn, txLaneCount, txRateSel;
  wire [15:0] txData;
  wire [3:0]  txPinState;
  wire [63:0] txTiming0, txTiming1;
  wire        sdaIn = sdaM & ~sdaOe;
  // bench state
  integer     fails = 0, cmp_count = 0, seed = 52, rnd, n, k, len;
  reg [7:0]   rd, b;
  reg         ack, sawPass = 1'b0, errPass = 1'b0;
  reg [63:0]  e;
  reg [20:0]  t;
  cto_tx_output_control uut (.*);
  cto_csi_sink snk (.clk(ref_clk), .txData(txData), .txValid(txValid), .txLast(txLast), .txReady(txReady));
  always #12.5 ref_clk = ~ref_clk;
  // note any pass flag, cut a hang short
  always @(posedge ref_clk) begin
    if (txStatusOut === 1'b1) sawPass <= 1'b1;
    if (txStatusOut !== 1'b0 && rxError[0]) errPass <= 1'b1;
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    fails = fails + 1;
    conclude;
  end
  task w(input integer c);
    repeat (c) @(posedge ref_clk);
  endtask
  task chk(input [63:0] g, input [63:0] x);
    begin
      cmp_count = cmp_count + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("mismatch %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task conclude;
    begin
      if (fails == 0 && cmp_count > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // one 200 ns serial bit, data moved only while the clock line is low
  task ibit(input v, output s);
    begin
      sdaM <= v;
      w(2);
      scl <= 1'b1;
      w(4);
      s = sdaIn;
      scl <= 1'b0;
      w(2);
    end
  endtask
  task framing(input st);
    begin
      sdaM <= st;
      w(2);
      scl <= 1'b1;
      w(2);
      sdaM <= ~st;
      w(2);
      scl <= ~st;
      w(2);
    end
  endtask
  task xbyte(input [7:0] o);
    integer j;
    begin
      for (j = 7; j >= 0; j = j - 1)
        ibit(o[j], rd[j]);
      ibit(1'b1, ack);
    end
  endtask
  task regWr(input [7:0] a, input [7:0] v);
    begin
      framing(1'b1);
      xbyte({`CTO_I2C_ADDR, 1'b0});
      chk(ack, 1'b0);
      xbyte(a);
      xbyte(v);
      framing(1'b0);
    end
  endtask
  task regRd(input [7:0] a);
    begin
      framing(1'b1);
      xbyte({`CTO_I2C_ADDR, 1'b0});
      xbyte(a);
      framing(1'b1);
      xbyte({`CTO_I2C_ADDR, 1'b1});
      xbyte(8'hFF);
      framing(1'b0);
    end
  endtask
  // stream bytes counting up from b, held until taken
  task send(input integer p, input integer cnt, input fin);
    integer j;
    begin
      for (j = 0; j < cnt; j = j + 1) begin
        rxValid[p] <= 1'b1;
        rxData[p*8 +: 8] <= b;
        rxLast[p] <= fin && j == cnt - 1;
        @(negedge ref_clk);
        while (!rxReady[p]) @(negedge ref_clk);
        @(posedge ref_clk);
        b = b + 8'h01;
      end
      rxValid[p] <= 1'b0;
      rxLast[p] <= 1'b0;
    end
  endtask
  // address and reset value; the last two are read-only, and the first of them is unmapped
  function [15:0] rtab(input integer i);
    case (i)
      0: rtab = {`CTO_REG_GEN_CFG, `CTO_RST_GEN_CFG};
      1: rtab = {`CTO_REG_RATE, `CTO_RST_RATE};
      2: rtab = {`CTO_REG_FWD1, `CTO_RST_FWD1};
      3: rtab = {`CTO_REG_FWD2, `CTO_RST_FWD2};
      4: rtab = {`CTO_REG_TX_CTL, `CTO_RST_TX_CTL};
      5: rtab = 16'h7E00;
      default: rtab = {`CTO_REG_TX_STS, 8'h00};
    endcase
  endfunction
  // general config, forwarding, lock, power pin, expected port 0 pin state
  function [20:0] ptab(input integer i);
    case (i)
      0: ptab = {8'h01, 8'h00, 2'h3, 1'b1, `CTO_PIN_HS0};
      1: ptab = {8'h02, 8'h00, 2'h3, 1'b1, `CTO_PIN_HIZ};
      2: ptab = {8'h03, 8'h00, 2'h0, 1'b1, `CTO_PIN_HIZ};
      3: ptab = {8'h07, 8'h00, 2'h0, 1'b1, `CTO_PIN_LP11};
      4: ptab = {8'h03, 8'h30, 2'h3, 1'b1, `CTO_PIN_LP11};
      5: ptab = {8'h03, 8'h00, 2'h2, 1'b1, `CTO_PIN_LP11};
      default: ptab = {8'h03, 8'h00, 2'h3, 1'b0, `CTO_PIN_HIZ};
    endcase
  endfunction
  // main sequence
  initial begin
    w(6);
    arst_n <= 1'b1;
    w(5);
    for (n = 0; n < 7; n = n + 1) begin
      t = rtab(n);
      if (n == 6) regWr(t[15:8], 8'hFF);
      regRd(t[15:8]);
      chk(rd, t[7:0]);
    end
    for (n = 0; n < 4; n = n + 1) begin
      regWr(`CTO_REG_RATE, n[7:0]);
      w(4);
      chk(txRateSel, n[1:0]);
      chk(pllLowRate, n == 3);
      chk(refScaleAlt, n == 1);
      chk(txTiming0, `CTO_TIM_AUTO);
    end
    regWr(`CTO_REG_TX_CTL, 8'h51);
    w(4);
    chk(txTiming0, `CTO_TIM_RESET);
    chk(txLaneCount, 2'h1);
    regWr(`CTO_REG_IND_CTL, 8'h02);
    regWr(`CTO_REG_IND_IDX, 8'h40);
    for (n = 0; n < 8; n = n + 1) begin
      rnd = $random(seed);
      e[n*8 +: 8] = rnd[7:0];
      regWr(`CTO_REG_IND_DATA, rnd[7:0]);
    end
    w(4);
    chk(txTiming0, e);
    chk(txTiming1, `CTO_TIM_RESET);
    for (n = 0; n < 7; n = n + 1) begin
      t = ptab(n);
      regWr(`CTO_REG_GEN_CFG, t[20:13]);
      regWr(`CTO_REG_FWD1, t[12:5]);
      rxLock <= t[4:3];
      powerDownPinN <= t[2];
      w(6);
      chk(txPinState[1:0], t[1:0]);
    end
    powerDownPinN <= 1'b1;
    regRd(`CTO_REG_TX_STS);
    chk(rd[1], 1'b0);
    regWr(`CTO_REG_FWD2, 8'h01);
    regRd(`CTO_REG_TX_STS);
    chk(rd[1], 1'b1);
    regWr(`CTO_REG_FWD2, 8'h20);
    w(4);
    chk(txClkLaneEn[1], 1'b1);
    chk(txTiming1, e);
    for (n = 0; n < 3; n = n + 1) begin
      rnd = $random(seed);
      len = 3 + rnd[3:0];
      b = rnd[15:8];
      send(0, len - 1, 1'b0);
      w(10);
      chk(txValid, 2'h0);
      send(0, 1, 1'b1);
      for (k = 0; k < 400 && (snk.q0.size() < len || snk.q1.size() < len); k = k + 1) w(1);
      for (k = 0; k < len; k = k + 1) begin
        chk(snk.q0[k], {k == len - 1, rnd[15:8] + k[7:0]});
        chk(snk.q1[k], {k == len - 1, rnd[15:8] + k[7:0]});
      end
      snk.q0.delete();
      snk.q1.delete();
    end
    chk(sawPass, 1'b1);
    w(30);
    chk(txStatusOut, 1'b0);
    // a packet forwarded under a video error never shows the pass flag
    rxError <= 2'h1;
    send(0, 3, 1'b1);
    for (k = 0; k < 400 && snk.q1.size() < 3; k = k + 1) w(1);
    rxError <= 2'h0;
    chk(snk.q1.size(), 3);
    chk(errPass, 1'b0);
    snk.q0.delete();
    snk.q1.delete();
    regWr(`CTO_REG_FWD2, 8'h00);
    regWr(`CTO_REG_FWD1, 8'h22);
    b = 8'h00;
    send(1, 16384, 1'b1);
    @(negedge ref_clk);
    chk(rxReady[1], 1'b0);
    @(posedge ref_clk);
    regWr(`CTO_REG_FWD1, 8'h02);
    for (k = 0; k < 60000 && snk.q1.size() < 16384; k = k + 1) w(1);
    chk(snk.q1.size(), 16384);
    chk(snk.q1[16383], 9'h1FF);
    conclude;
  end
endmodule // cto_tx_output_control_tb
